/* File: logic/sensor_serial_link.sv */
// Two-wire serial slave of the sensor, with its receive FIFO.
// Assumes scl and sda are sampled by clk_in; SCL period well above 8 cycles.
`timescale 1ns/1ps
`default_nettype none
`include "sensor_serial_consts.svh"

module sensor_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    input  wire logic [WIDTH-1:0] wr_data_in,
    input  wire logic             wr_valid_in,
    output logic                  wr_ready_out,
    output logic      [WIDTH-1:0] rd_data_out,
    output logic                  rd_valid_out,
    input  wire logic             rd_ready_in
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      count_r, count_nxt;
    logic [AW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
    logic             push, pop;

    // Honest full and empty from the count
    assign push         = wr_valid_in && (count_r != (AW+1)'(DEPTH));
    assign pop          = rd_ready_in && (count_r != '0);
    assign wr_ready_out = (count_r != (AW+1)'(DEPTH));
    assign rd_valid_out = (count_r != '0);
    assign rd_data_out  = mem[rp_r];

    always_comb begin
        count_nxt = count_r + (AW+1)'(push) - (AW+1)'(pop);
        wp_nxt    = push ? AW'(wp_r + 1'b1) : wp_r;
        rp_nxt    = pop ? AW'(rp_r + 1'b1) : rp_r;
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            count_r <= '0;
            wp_r    <= '0;
            rp_r    <= '0;
        end else begin
            count_r <= count_nxt;
            wp_r    <= wp_nxt;
            rp_r    <= rp_nxt;
        end
    end

    // Storage has no reset; it is only read once written
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem[wp_r] <= wr_data_in;
        end
    end
endmodule : sensor_fifo

module sensor_serial_link
    import sensor_serial_pkg::*;
#(
    parameter longint POWERUP_CYCLES = `POWERUP_CYCLES
) (
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_out,
    output logic      [7:0] rx_data_out,
    output logic            rx_valid_out,
    input  wire logic       rx_ready_in,
    input  wire logic [7:0] tx_data_in,
    output logic            tx_take_out,
    output logic            ready_out,
    output logic            busy_out
);
    link_state_t state_r, state_nxt;
    logic [1:0]  scl_sync_r, sda_sync_r;
    logic        scl_d_r, sda_d_r;
    logic [3:0]  bit_r, bit_nxt;
    logic [7:0]  shift_r, shift_nxt;
    logic        oe_r, oe_nxt, take_r, take_nxt, push_r, push_nxt;
    logic [7:0]  push_data_r, push_data_nxt;
    logic [31:0] wake_r, wake_nxt;
    logic        scl_rise, scl_fall, start_c, stop_c, fifo_ready;
    logic        fifo_valid, busy_r, busy_nxt, ready_r, ready_nxt, hdr_r, hdr_nxt;
    logic [7:0]  fifo_data;

    // Two-flop synchronisers; the edge detectors see only stage two
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            scl_sync_r <= 2'h3;
            sda_sync_r <= 2'h3;
            scl_d_r    <= 1'b1;
            sda_d_r    <= 1'b1;
        end else begin
            scl_sync_r <= {scl_sync_r[0], scl_in};
            sda_sync_r <= {sda_sync_r[0], sda_in};
            scl_d_r    <= scl_sync_r[1];
            sda_d_r    <= sda_sync_r[1];
        end
    end

    // edge driven only, no timeouts on the serial clock
    assign scl_rise = scl_sync_r[1] && !scl_d_r;
    assign scl_fall = !scl_sync_r[1] && scl_d_r;
    assign start_c  = scl_sync_r[1] && scl_d_r && sda_d_r && !sda_sync_r[1];
    assign stop_c   = scl_sync_r[1] && scl_d_r && !sda_d_r && sda_sync_r[1];

    // Bit-level state machine
    always_comb begin
        state_nxt     = state_r;
        bit_nxt       = bit_r;
        shift_nxt     = shift_r;
        oe_nxt        = oe_r;
        take_nxt      = 1'b0;
        push_nxt      = 1'b0;
        push_data_nxt = push_data_r;
        wake_nxt      = wake_r;
        hdr_nxt       = hdr_r;
        if (state_r == ST_WAKE) begin
            // settle with clock high before accepting anything
            wake_nxt = scl_sync_r[1] ? wake_r + 32'h1 : 32'h0;
            if (longint'(wake_r) >= POWERUP_CYCLES - 1) begin
                state_nxt = ST_IDLE;
            end
        end else if (start_c) begin
            state_nxt = ST_RECV;
            bit_nxt   = 4'h0;
            oe_nxt    = 1'b0;
            hdr_nxt   = 1'b1; // Next byte is the address byte
        end else if (stop_c) begin
            state_nxt = ST_IDLE;
            oe_nxt    = 1'b0;
        end else begin
            unique case (state_r)
                ST_IDLE, ST_IGNORE: begin
                    oe_nxt = 1'b0;
                end
                ST_RECV: begin
                    if (scl_rise) begin
                        shift_nxt = {shift_r[6:0], sda_sync_r[1]};
                        bit_nxt   = bit_r + 4'h1;
                    end else if (scl_fall && bit_r == `BITS_PER_BYTE) begin
                        // header check; ack after eighth fall
                        if (hdr_r && shift_r[7:1] != `DEV_ADDR) begin
                            state_nxt = ST_IGNORE;
                        end else if (!hdr_r && !fifo_ready) begin
                            state_nxt = ST_IGNORE;
                        end else begin
                            state_nxt = ST_ACK;
                            oe_nxt    = 1'b1;
                            if (!hdr_r) begin
                                push_nxt      = 1'b1;
                                push_data_nxt = shift_r;
                            end
                        end
                    end
                end
                ST_ACK, ST_MACK: begin
                    // Host ack keeps a read going; a host nack ends it
                    if (scl_rise && state_r == ST_MACK) begin
                        state_nxt = sda_sync_r[1] ? ST_IGNORE : ST_MACK;
                    end else if (scl_fall) begin
                        bit_nxt = 4'h0;
                        hdr_nxt = 1'b0;
                        if ((hdr_r && shift_r[0]) || state_r == ST_MACK) begin
                            // first read bit set just after the fall
                            state_nxt = ST_SEND;
                            shift_nxt = tx_data_in;
                            take_nxt  = 1'b1;
                            oe_nxt    = !tx_data_in[7];
                        end else begin
                            state_nxt = ST_RECV;
                            oe_nxt    = 1'b0;
                        end
                    end
                end
                ST_SEND: begin
                    if (scl_fall) begin
                        bit_nxt = bit_r + 4'h1;
                        if (bit_r == `BITS_PER_BYTE - 4'h1) begin
                            state_nxt = ST_MACK;
                            oe_nxt    = 1'b0;
                        end else begin
                            // next bit after fall, held a full period
                            shift_nxt = {shift_r[6:0], 1'b0};
                            oe_nxt    = !shift_r[6];
                        end
                    end
                end
                default: begin
                    state_nxt = ST_IDLE;
                end
            endcase
        end
        // Flags taken from the next state so the outputs come from flops
        busy_nxt  = (state_nxt != ST_IDLE) && (state_nxt != ST_WAKE);
        ready_nxt = (state_nxt != ST_WAKE);
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_r     <= ST_WAKE;
            bit_r       <= 4'h0;
            shift_r     <= 8'h00;
            oe_r        <= 1'b0;
            take_r      <= 1'b0;
            push_r      <= 1'b0;
            push_data_r <= 8'h00;
            wake_r      <= 32'h0;
            hdr_r       <= 1'b0;
            busy_r      <= 1'b0;
            ready_r     <= 1'b0;
        end else begin
            state_r     <= state_nxt;
            bit_r       <= bit_nxt;
            shift_r     <= shift_nxt;
            oe_r        <= oe_nxt;
            take_r      <= take_nxt;
            push_r      <= push_nxt;
            push_data_r <= push_data_nxt;
            wake_r      <= wake_nxt;
            hdr_r       <= hdr_nxt;
            busy_r      <= busy_nxt;
            ready_r     <= ready_nxt;
        end
    end

    // Received bytes wait here; a full FIFO makes the device not acknowledge
    sensor_fifo #(
        .WIDTH (`BYTE_WIDTH),
        .DEPTH (`FIFO_DEPTH)
    ) u_rx_fifo (
        .clk_in       (clk_in),
        .rst_n_in     (rst_n_in),
        .wr_data_in   (push_data_r),
        .wr_valid_in  (push_r),
        .wr_ready_out (fifo_ready),
        .rd_data_out  (fifo_data),
        .rd_valid_out (fifo_valid),
        .rd_ready_in  (rx_ready_in)
    );

    // data driven low only: output fixed low, enable pulls
    assign sda_out      = 1'b0;
    assign sda_oe_out   = oe_r;
    assign tx_take_out  = take_r;
    assign ready_out    = ready_r;
    assign busy_out     = busy_r;
    assign rx_data_out  = fifo_data;
    assign rx_valid_out = fifo_valid;

    // acknowledge held low across the ninth clock
    ack_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (state_r == ST_ACK && !scl_fall) |-> sda_oe_out) else $error("ack not driven");
    // read data stable while clock high
    send_stable_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (state_r == ST_SEND && !scl_fall && !start_c && !stop_c) |=> $stable(sda_oe_out))
        else $error("read bit moved");
    wake_quiet_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (state_r == ST_WAKE) |-> !sda_oe_out && !busy_out) else $error("active during wake");
    low_only_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        sda_oe_out |-> !sda_out) else $error("line driven high");
    start_recv_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (start_c && state_r != ST_WAKE) |=> state_r == ST_RECV && bit_r == 4'h0) else $error("start missed");
    stop_idle_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (stop_c && !start_c && state_r != ST_WAKE) |=> state_r == ST_IDLE && !sda_oe_out) else $error("stop missed");
    addr_nack_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (state_r == ST_RECV && hdr_r && scl_fall && bit_r == 4'h8 && shift_r[7:1] != `DEV_ADDR
         && !start_c && !stop_c) |=> !sda_oe_out) else $error("foreign address acked");
    rise_count_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (state_r == ST_RECV && scl_rise && !start_c && !stop_c) |=> bit_r == $past(bit_r) + 4'h1) else $error("bit not sampled");
endmodule : sensor_serial_link

`default_nettype wire

/* File: pkg/sensor_serial_consts.svh */
// Constants of the sensor serial bit interface.
// Assumes a 250 MHz system clock; included by bare name.
`ifndef SENSOR_SERIAL_CONSTS_SVH
`define SENSOR_SERIAL_CONSTS_SVH
`define DEV_ADDR          7'h40
`define CLK_PERIOD_PS     4000
`define POWERUP_WAIT_MS   15
`define POWERUP_CYCLES    ((`POWERUP_WAIT_MS * 64'd1000000000) / `CLK_PERIOD_PS)
`define BITS_PER_BYTE     4'h8
`define FIFO_DEPTH        8
`define BYTE_WIDTH        8
`endif

/* File: pkg/sensor_serial_pkg.sv */
// Types of the sensor serial bit interface.
// Assumes nothing beyond the constants header.
package sensor_serial_pkg;
    typedef enum logic [2:0] {
        ST_WAKE,
        ST_IDLE,
        ST_RECV,
        ST_ACK,
        ST_SEND,
        ST_MACK,
        ST_IGNORE
    } link_state_t;
endpackage : sensor_serial_pkg

/* File: sim/host_model.sv */
// Host side model: bit-banged two-wire master.
// Assumes a pull-up on data and a sensor that only pulls it low.
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input  wire logic clk_in,
    input  wire logic sda_oe_in,
    output logic      scl_out,
    output logic      sda_out,
    output int        glitches
);
    logic pull_r;
    int   half;
    // Wired-and of both pull-downs; released line floats high
    assign sda_out = ~(pull_r | sda_oe_in);
    initial begin
        scl_out  = 1'b1;
        pull_r   = 1'b0;
        half     = 20;
        glitches = 0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
    endtask : tick
    task automatic start_cond();
        tick(4);
        pull_r <= 1'b0;
        tick(half);
        scl_out <= 1'b1;
        tick(half);
        pull_r <= 1'b1;
        tick(half);
        scl_out <= 1'b0;
    endtask : start_cond
    task automatic stop_cond();
        tick(4);
        pull_r <= 1'b1;
        tick(half);
        scl_out <= 1'b1;
        tick(half);
        pull_r <= 1'b0;
        tick(half);
    endtask : stop_cond
    // data set while low, held through high
    task automatic clock_bit(input logic b, output logic seen);
        tick(4); // Margin so data never moves near the fall
        pull_r <= ~b;
        tick(half);
        scl_out <= 1'b1;
        tick(half / 2);
        seen = sda_out;
        tick(half / 2);
        if (sda_out !== seen) glitches++;
        scl_out <= 1'b0;
    endtask : clock_bit
    task automatic write_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) clock_bit(d[i], s);
        clock_bit(1'b1, s);
        ack = ~s;
    endtask : write_byte
    task automatic read_byte(input logic mack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) clock_bit(1'b1, d[i]);
        clock_bit(~mack, s);
    endtask : read_byte
endmodule : host_model
`default_nettype wire

/* File: sim/sensor_serial_bit_interface_bench.sv */
// Testbench of the sensor serial link against the host model.
// Assumes a short power-up count of 50 cycles.
`timescale 1ns/1ps
`default_nettype none
module sensor_serial_bit_interface_bench;
    logic       clk_in, rst_n_in, rx_ready_in, sda_oe, sda_drv, scl, sda;
    logic       rx_valid, tx_take, ready, busy, a;
    logic [7:0] tx_data_in, rx_data, d;
    int         num_errors, checks, takes, glitches, high_drives, n;
    sensor_serial_link #(.POWERUP_CYCLES(50)) uut (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_drv), .sda_oe_out(sda_oe), .rx_data_out(rx_data),
        .rx_valid_out(rx_valid), .rx_ready_in(rx_ready_in), .tx_data_in(tx_data_in),
        .tx_take_out(tx_take), .ready_out(ready), .busy_out(busy));
    host_model host (.clk_in(clk_in), .sda_oe_in(sda_oe), .scl_out(scl),
        .sda_out(sda), .glitches(glitches));
    initial begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end
    // Tally take pulses and any attempt to drive data high
    always @(posedge clk_in) begin
        if (tx_take === 1'b1) takes++;
        if (sda_oe === 1'b1 && sda_drv !== 1'b0) high_drives++;
    end
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic final_report();
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : final_report
    task automatic test_powerup();
        check("ready_rst", {7'h00, ready}, 8'h00);
        check("oe_rst", {7'h00, sda_oe}, 8'h00);
        rst_n_in <= 1'b1;
        repeat (20) @(posedge clk_in);
        check("ready_early", {7'h00, ready}, 8'h00);
        n = 0;
        while (ready !== 1'b1 && n < 200) begin
            @(posedge clk_in);
            n++;
        end
        if (n == 200) begin
            num_errors++;
            final_report();
        end
        check("ready", {7'h00, ready}, 8'h01);
        $display("test powerup done");
    endtask : test_powerup
    task automatic test_fill();
        host.start_cond();
        host.write_byte(8'h80, a);
        check("hdr_ack", {7'h00, a}, 8'h01);
        // First byte is the soft reset command; ninth meets a full FIFO
        for (int i = 0; i < 9; i++) begin
            host.write_byte(i == 0 ? 8'hFE : 8'(8'h11 * i), a);
            check("data_ack", {7'h00, a}, {7'h00, i < 8});
        end
        host.stop_cond();
        for (int i = 0; i < 8; i++) begin
            check("rx_valid", {7'h00, rx_valid}, 8'h01);
            check("rx_data", rx_data, i == 0 ? 8'hFE : 8'(8'h11 * i));
            rx_ready_in <= 1'b1;
            @(posedge clk_in);
            rx_ready_in <= 1'b0;
            @(posedge clk_in);
        end
        check("drained", {7'h00, rx_valid}, 8'h00);
        $display("test fill done");
    endtask : test_fill
    task automatic test_bad_addr();
        host.start_cond();
        host.write_byte(8'h82, a);
        check("bad_hdr", {7'h00, a}, 8'h00);
        host.write_byte(8'h55, a);
        check("ignored", {7'h00, a}, 8'h00);
        host.stop_cond();
        check("no_store", {7'h00, rx_valid}, 8'h00);
        $display("test bad address done");
    endtask : test_bad_addr
    task automatic test_read();
        tx_data_in <= 8'h5A;
        host.half = 60; // Slower serial clock
        host.start_cond();
        host.write_byte(8'h81, a);
        check("rd_ack", {7'h00, a}, 8'h01);
        check("busy", {7'h00, busy}, 8'h01);
        host.read_byte(1'b1, d);
        tx_data_in <= 8'hC3;
        check("rd0", d, 8'h5A);
        host.read_byte(1'b0, d);
        check("rd1", d, 8'hC3);
        host.stop_cond();
        check("idle", {7'h00, busy}, 8'h00);
        check("takes", 8'(takes), 8'h02);
        check("glitches", 8'(glitches), 8'h00);
        check("high_drive", 8'(high_drives), 8'h00);
        host.half = 20;
        $display("test read done");
    endtask : test_read
    initial begin
        rst_n_in    = 1'b0;
        rx_ready_in = 1'b0;
        tx_data_in  = 8'h00;
        num_errors  = 0;
        checks      = 0;
        takes       = 0;
        high_drives = 0;
        repeat (16) @(posedge clk_in);
        test_powerup();
        test_fill();
        test_bad_addr();
        test_read();
        final_report();
    end
endmodule : sensor_serial_bit_interface_bench
`default_nettype wire
